// ==== include/acr_pkg.sv ====
/*
 Package for the converter control and result readout block:
 frame layout, timing figures and port states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package acr_pkg;
	// ----------------------------------------
	// Clock rates
	// ----------------------------------------
	localparam int ACR_CLK_HZ = 10000000; // System clock
	localparam int ACR_MCLK_HZ = 32768; // Nominal master clock
	// Divider, rounded down
	localparam int ACR_MCLK_DIV = ACR_CLK_HZ / ACR_MCLK_HZ;

	// ----------------------------------------
	// Conversion timing, master clock cycles
	// ----------------------------------------
	localparam int ACR_FIRST_MCLK = 7358; // After a channel toggle
	localparam int ACR_NEXT_MCLK = 4884; // Each further word
	localparam int ACR_CAL_MCLK = 256; // Each calibration step
	localparam int ACR_CNT_W = 13; // Conversion counter width

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int ACR_FRAME_W = 32;
	localparam int ACR_DATA_W = 24;
	localparam int ACR_STATUS_BITS = 8;
	localparam logic [4:0] ACR_PATTERN = 5'h0f; // Top five bits 0,1,1,1,1
	localparam int ACR_CH_BIT = 26;
	localparam int ACR_OD_BIT = 25;
	localparam int ACR_OF_BIT = 24;
	localparam logic [23:0] ACR_POS_FS = 24'h7fffff;
	localparam logic [23:0] ACR_NEG_FS = 24'h800000;
	localparam logic [31:0] ACR_RESULT_RESET = 32'hffffffff;

	// ----------------------------------------
	// Filter sample path
	// ----------------------------------------
	localparam int ACR_SAMP_W = 26; // Signed filter output
	localparam int ACR_FIFO_DEPTH = 16;

	// Serial port states
	typedef enum logic [1:0] {
		ACR_IDLE = 2'b00,
		ACR_READY = 2'b01,
		ACR_SHIFT = 2'b10
	} acr_port_e;
endpackage
`default_nettype wire

// ==== hw/acr_top.sv ====
/*
 Digital control and readout of a two channel delta-sigma converter:
 sample FIFO, conversion timer, channel select, result framing and the
 serial output port.
 Assumes the filter delivers signed samples with valid/ready, and that
 chip select, shift clock and channel select are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Sample FIFO
// ----------------------------------------
module acr_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [AW-1:0] wr_ptr; // Write index
	logic [AW-1:0] rd_ptr; // Read index
	logic [AW:0] count; // Words held
	logic push;
	logic pop;
	logic [AW:0] next_count;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];
	assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	// Storage write, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= next_count;
		end
	end

	// Flags kept in flops so the ports are registered
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			in_ready <= next_count != (AW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end
endmodule

// ----------------------------------------
// Converter control and readout
// ----------------------------------------
module acr_top
	import acr_pkg::*;
#(
	parameter int MCLK_DIV = acr_pkg::ACR_MCLK_DIV,
	parameter int FIRST_MCLK = acr_pkg::ACR_FIRST_MCLK,
	parameter int NEXT_MCLK = acr_pkg::ACR_NEXT_MCLK,
	parameter int CAL_MCLK = acr_pkg::ACR_CAL_MCLK,
	parameter int FIFO_DEPTH = acr_pkg::ACR_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Filter sample stream
	input wire logic sample_valid,
	input wire logic [acr_pkg::ACR_SAMP_W-1:0] sample_data,
	input wire logic sample_osc,
	output logic sample_ready,
	// Pins
	input wire logic channel_select_pin,
	input wire logic cs_n,
	input wire logic sclk,
	output logic serial_output_line,
	output logic serial_output_oe_n,
	// Analog steering
	output logic input_pair_sel,
	output logic cal_offset_active,
	output logic cal_gain_active
);
	import acr_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int DW = $clog2(MCLK_DIV + 1);
	localparam logic [ACR_CNT_W-1:0] FIRST_C = ACR_CNT_W'(FIRST_MCLK);
	localparam logic [ACR_CNT_W-1:0] NEXT_C = ACR_CNT_W'(NEXT_MCLK);
	localparam logic [ACR_CNT_W-1:0] CAL_C = ACR_CNT_W'(CAL_MCLK);
	logic [DW-1:0] div_cnt; // Master clock divider
	logic mclk_tick; // One cycle per master clock
	logic [2:0] chs_sync; // Channel select synchroniser + history
	logic [2:0] cs_sync; // Chip select synchroniser
	logic [2:0] sclk_sync; // Shift clock synchroniser + history
	logic chs_change; // Select toggled
	logic sclk_fall; // Qualified falling edge
	logic [ACR_CNT_W-1:0] conv_cnt; // Master clocks to completion
	logic conv_chan; // Pair under conversion
	logic conv_done; // Completion pulse
	logic pre_done; // Last master clock of a conversion
	acr_port_e port_state; // Serial port state
	logic [5:0] bit_cnt; // Falling edges seen in a read
	logic [ACR_FRAME_W-1:0] conversion_result_word; // Frame shifter
	logic [ACR_FRAME_W-1:0] next_frame; // Frame built at completion
	logic fifo_valid;
	logic [ACR_SAMP_W:0] fifo_data; // {osc, sample}
	logic signed [ACR_SAMP_W-1:0] samp; // Head sample
	logic over_pos;
	logic over_neg;
	logic [ACR_DATA_W-1:0] sat_data;
	logic od_flag; // Oscillation flag
	logic of_flag; // Overrange flag
	logic [ACR_DATA_W-1:0] last_data; // Held when FIFO is empty

	// ----------------------------------------
	// Master clock enable
	// ----------------------------------------
	// The conversion timer counts these ticks, so its period scales with MCLK_DIV
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_cnt <= '0;
		end else if (div_cnt == DW'(MCLK_DIV - 1)) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end
	assign mclk_tick = div_cnt == DW'(MCLK_DIV - 1);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Bit 0 feeds only bit 1; logic reads bits 1 and 2
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			chs_sync <= 3'h0;
			cs_sync <= 3'h7;
			sclk_sync <= 3'h0;
		end else begin
			chs_sync <= {chs_sync[1:0], channel_select_pin};
			cs_sync <= {cs_sync[1:0], cs_n};
			sclk_sync <= {sclk_sync[1:0], sclk};
		end
	end
	assign chs_change = chs_sync[1] != chs_sync[2];
	// Edges count only while selected and with a word on offer
	assign sclk_fall = sclk_sync[2] && !sclk_sync[1] && !cs_sync[1]
		&& (port_state != ACR_IDLE);

	// ----------------------------------------
	// Conversion timer
	// ----------------------------------------
	assign pre_done = conv_cnt == ACR_CNT_W'(1);
	assign conv_done = mclk_tick && pre_done && !chs_change;

	// Restart on any select change, else count down and reload
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			conv_cnt <= FIRST_C;
			conv_chan <= 1'b0;
		end else if (chs_change) begin
			conv_cnt <= FIRST_C;
			conv_chan <= chs_sync[1];
		end else if (mclk_tick) begin
			conv_cnt <= pre_done ? NEXT_C : conv_cnt - 1'b1;
		end
	end

	// Steering and calibration windows at the end of each period
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			input_pair_sel <= 1'b0;
			cal_offset_active <= 1'b0;
			cal_gain_active <= 1'b0;
		end else begin
			input_pair_sel <= conv_chan;
			cal_offset_active <= conv_cnt > CAL_C
				&& conv_cnt <= 2 * CAL_C;
			cal_gain_active <= conv_cnt <= CAL_C;
		end
	end

	// ----------------------------------------
	// Sample FIFO, drained once per conversion
	// ----------------------------------------
	acr_fifo #(
		.WIDTH(ACR_SAMP_W + 1),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_valid(sample_valid),
		.in_data({sample_osc, sample_data}),
		.in_ready(sample_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(conv_done)
	);

	// ----------------------------------------
	// Result framing
	// ----------------------------------------
	assign samp = fifo_data[ACR_SAMP_W-1:0];
	assign over_pos = samp > $signed({{(ACR_SAMP_W-ACR_DATA_W){1'b0}}, ACR_POS_FS});
	assign over_neg = samp < $signed({{(ACR_SAMP_W-ACR_DATA_W){1'b1}}, ACR_NEG_FS});

	// Saturate instead of wrapping so overrange never flips sign
	always_comb begin
		if (over_pos) begin
			sat_data = ACR_POS_FS;
		end else if (over_neg) begin
			sat_data = ACR_NEG_FS;
		end else begin
			sat_data = samp[ACR_DATA_W-1:0];
		end
	end

	// Flags follow each word; empty FIFO repeats the last word
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			od_flag <= 1'b0;
			of_flag <= 1'b0;
			last_data <= '0;
		end else if (conv_done && fifo_valid) begin
			od_flag <= fifo_data[ACR_SAMP_W];
			of_flag <= over_pos || over_neg;
			last_data <= sat_data;
		end
	end

	// Frame assembled from the values about to be stored
	always_comb begin
		next_frame = {ACR_PATTERN, conv_chan, od_flag, of_flag, last_data};
		if (fifo_valid) begin
			next_frame = {ACR_PATTERN, conv_chan, fifo_data[ACR_SAMP_W],
				over_pos || over_neg, sat_data};
		end
	end

	// ----------------------------------------
	// Serial port
	// ----------------------------------------
	// A read in progress is never overwritten; its newer word is lost
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			port_state <= ACR_IDLE;
			bit_cnt <= '0;
			conversion_result_word <= ACR_RESULT_RESET;
		end else if (conv_done && port_state != ACR_SHIFT) begin
			port_state <= ACR_READY;
			bit_cnt <= '0;
			conversion_result_word <= next_frame;
		end else if (sclk_fall) begin
			// Shift one bit per falling edge, MSB first
			conversion_result_word <= {conversion_result_word[30:0], 1'b1};
			if (bit_cnt == 6'(ACR_FRAME_W - 1)) begin
				port_state <= ACR_IDLE;
				bit_cnt <= '0;
			end else begin
				port_state <= ACR_SHIFT;
				bit_cnt <= bit_cnt + 1'b1;
			end
		end
	end

	// Output pin registered; high when idle, early rise before reload
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			serial_output_line <= 1'b1;
			serial_output_oe_n <= 1'b1;
		end else begin
			serial_output_oe_n <= cs_sync[1];
			case (port_state)
				ACR_READY: begin
					serial_output_line <= pre_done
						|| conversion_result_word[31];
				end
				ACR_SHIFT: begin
					serial_output_line <= conversion_result_word[31];
				end
				default: begin
					serial_output_line <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_fall_at(int n);
		sclk_fall && port_state == ACR_SHIFT && bit_cnt == 6'(n);
	endsequence

	property p_restart;
		@(posedge clk) disable iff (reset)
		chs_change |=> conv_cnt == FIRST_C && conv_chan == $past(chs_sync[1]);
	endproperty
	a_restart: assert property (p_restart) else $error("restart count wrong");

	property p_reload;
		@(posedge clk) disable iff (reset)
		conv_done |=> conv_cnt == NEXT_C;
	endproperty
	a_reload: assert property (p_reload) else $error("reload count wrong");

	property p_frame;
		@(posedge clk) disable iff (reset)
		conv_done && port_state != ACR_SHIFT |=> port_state == ACR_READY
			&& conversion_result_word[31:27] == ACR_PATTERN
			&& conversion_result_word[ACR_CH_BIT] == $past(conv_chan);
	endproperty
	a_frame: assert property (p_frame) else $error("frame not loaded");

	property p_sat;
		@(posedge clk) disable iff (reset)
		conv_done && fifo_valid && over_neg && port_state != ACR_SHIFT
			|=> conversion_result_word[23:0] == ACR_NEG_FS
			&& conversion_result_word[ACR_OF_BIT];
	endproperty
	a_sat: assert property (p_sat) else $error("no saturation");

	property p_status_done;
		@(posedge clk) disable iff (reset)
		s_fall_at(7) |=> bit_cnt == 6'd8 ##1 serial_output_line == $past(conversion_result_word[31]);
	endproperty
	a_status_done: assert property (p_status_done) else $error("msb not after eighth");

	property p_end;
		@(posedge clk) disable iff (reset)
		s_fall_at(31) && !conv_done |=> port_state == ACR_IDLE ##1 serial_output_line;
	endproperty
	a_end: assert property (p_end) else $error("no idle after 32");

	property p_early_rise;
		@(posedge clk) disable iff (reset)
		port_state == ACR_READY && pre_done && !conv_done && !sclk_fall |=> serial_output_line;
	endproperty
	a_early_rise: assert property (p_early_rise) else $error("no early rise");

	property p_hiz;
		@(posedge clk) disable iff (reset)
		cs_sync[1] |=> serial_output_oe_n;
	endproperty
	a_hiz: assert property (p_hiz) else $error("driven while deselected");

	property p_ignore;
		@(posedge clk) disable iff (reset)
		cs_sync[1] && !conv_done |=> $stable(bit_cnt) && $stable(port_state);
	endproperty
	a_ignore: assert property (p_ignore) else $error("edge taken unselected");
endmodule
`default_nettype wire

// ==== tb/acr_host_model.sv ====
/*
 Host model: drives chip select and shift clock, reads 32-bit frames.
 Assumes the bench calls its tasks and drives these pins nowhere else.
*/
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
	// Clock
	input wire logic clk,
	// Device pins
	input wire logic dout,
	input wire logic dout_oe_n,
	output logic cs_n,
	output logic sclk
);
	logic last_drv; // Last driven level
	logic line; // Level seen on the wire
	// Released wire: inverse of last level, so stale data never passes
	always @(posedge clk) begin
		if (!dout_oe_n) last_drv <= dout;
	end
	assign line = dout_oe_n ? ~last_drv : dout;
	// Idle: deselected, shift clock low
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		last_drv = 1'b0;
	end
	// Select changes only with the shift clock low
	task automatic select(input logic on);
		@(negedge clk);
		cs_n = ~on;
	endtask
	// One read of 32 clocks, high then low; half sets the pace
	task automatic read_frame(input int half, output logic [31:0] f, output logic tail);
		f[31] = line;
		for (int k = 1; k <= 32; k++) begin
			@(negedge clk);
			sclk = 1'b1;
			repeat (half) @(negedge clk);
			sclk = 1'b0;
			repeat (half) @(negedge clk);
			if (k < 32) f[31-k] = line;
		end
		tail = line;
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
/*
 Testbench for the converter control and readout block.
 Assumes the host model owns chip select and shift clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	import acr_pkg::*;
	// ----------------------------------------
	// Short counts keep the run brief
	// ----------------------------------------
	localparam int DIV = 2;
	localparam int FIRST = 400;
	localparam int NEXT = 300;
	localparam int PER = NEXT * DIV;
	localparam int LIMIT = 30000; // Whole run needs about 16000
	logic clk, reset, sample_valid, sample_osc, sample_ready, chan_sel;
	logic cs_n, sclk, dout, dout_oe_n, pair_sel, cal_off, cal_gain;
	logic [ACR_SAMP_W-1:0] sample_data;
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	int last_fall = 0;
	int cal_seen = 0;
	acr_top #(.MCLK_DIV(DIV), .FIRST_MCLK(FIRST), .NEXT_MCLK(NEXT), .CAL_MCLK(4),
		.FIFO_DEPTH(16)) dut_u (.clk(clk), .reset(reset), .sample_valid(sample_valid),
		.sample_data(sample_data), .sample_osc(sample_osc), .sample_ready(sample_ready),
		.channel_select_pin(chan_sel), .cs_n(cs_n), .sclk(sclk),
		.serial_output_line(dout), .serial_output_oe_n(dout_oe_n),
		.input_pair_sel(pair_sel), .cal_offset_active(cal_off), .cal_gain_active(cal_gain));
	acr_host_model host_u (.clk(clk), .dout(dout), .dout_oe_n(dout_oe_n), .cs_n(cs_n),
		.sclk(sclk));
	// ----------------------------------------
	// Clock, cycle count and hang guard
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cal_off === 1'b1 || cal_gain === 1'b1) cal_seen = cal_seen + 1;
		if (cyc == LIMIT) begin
			mismatches = mismatches + 1;
			stop_test();
		end
	end
	// ----------------------------------------
	// Compare and bus tasks
	// ----------------------------------------
	task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks = checks + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_rng(input string name, input int lo, input int hi, input int got);
		checks = checks + 1;
		if (got < lo || got > hi) begin
			mismatches = mismatches + 1;
			$display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask
	function automatic logic [31:0] fr(input logic c, input logic o, input logic v,
		input logic [23:0] d);
		return {5'b01111, c, o, v, d};
	endfunction
	// Offer one sample; held until the FIFO takes it
	task automatic push(input logic [25:0] d, input logic osc);
		@(negedge clk);
		sample_valid = 1'b1;
		sample_data = d;
		sample_osc = osc;
		while (sample_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		sample_valid = 1'b0;
	endtask
	// Wait for the ready flag, bounded
	task automatic wait_fall();
		int n;
		n = 0;
		while (dout !== 1'b0 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		last_fall = cyc;
		chk_val("ready flag", 32'h0, {31'h0, dout});
	endtask
	// Read a frame and judge it; pin must then stay high
	task automatic take(input int half, input logic [31:0] exp);
		logic [31:0] f;
		logic t;
		host_u.read_frame(half, f, t);
		chk_val("frame", exp, f);
		chk_val("after read", 32'h1, {31'h0, t});
	endtask
	// Count high cycles until the pin falls again
	task automatic blip(output int n, output int h);
		n = 0;
		h = 0;
		while (!(h > 0 && dout === 1'b0) && n < 2000) begin
			@(negedge clk);
			n++;
			if (dout === 1'b1) h++;
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_start();
		chk_val("oe idle", 32'h1, {31'h0, dout_oe_n});
		host_u.select(1'b1);
		repeat (4) @(negedge clk);
		chk_val("oe selected", 32'h0, {31'h0, dout_oe_n});
		chk_val("early level", 32'h1, {31'h0, dout});
		push(26'h0123456, 1'b0);
		push(26'h0800000, 1'b1);
		wait_fall();
		take(5, fr(1'b0, 1'b0, 1'b0, 24'h123456));
		chk_val("pair", 32'h0, {31'h0, pair_sel});
	endtask
	// Positive overrange with oscillation, slow host
	task automatic t_overrange();
		int f0;
		f0 = last_fall;
		wait_fall();
		chk_rng("period", PER, PER, last_fall - f0);
		take(8, fr(1'b0, 1'b1, 1'b1, 24'h7fffff));
	endtask
	task automatic t_switch();
		int t0;
		@(negedge clk);
		chan_sel = 1'b1;
		t0 = cyc;
		push(26'h3000000, 1'b0);
		wait_fall();
		chk_rng("toggle to fall", FIRST * DIV, FIRST * DIV + DIV + 8, last_fall - t0);
		chk_val("pair", 32'h1, {31'h0, pair_sel});
		take(5, fr(1'b1, 1'b0, 1'b1, 24'h800000));
		t0 = last_fall;
		push(26'h3ffffff, 1'b0);
		wait_fall();
		chk_rng("period", PER, PER, last_fall - t0);
		take(5, fr(1'b1, 1'b0, 1'b0, 24'hffffff));
	endtask
	// Unread word, then a switch while the flag is low
	task automatic t_unread();
		int n, h;
		push(26'h0000055, 1'b0);
		push(26'h00000aa, 1'b0);
		push(26'h0000011, 1'b0);
		wait_fall();
		blip(n, h);
		chk_rng("rise width", 1, DIV + 1, h);
		chk_rng("refresh", PER - 1, PER + 1, n);
		@(negedge clk);
		chan_sel = 1'b0;
		blip(n, h);
		chk_rng("switch rise", 1, DIV + 1, h);
		chk_rng("switch to fall", FIRST * DIV - 1, FIRST * DIV + DIV + 8, n);
		take(5, fr(1'b0, 1'b0, 1'b0, 24'h000011));
	endtask
	// Fill until refused, then drain with the host
	task automatic t_fifo();
		logic [23:0] v;
		for (int i = 0; i < 16; i++) begin
			v = (24'h000001 << i) ^ {24{i[0]}};
			push({{2{v[23]}}, v}, 1'b0);
		end
		chk_val("full", 32'h0, {31'h0, sample_ready});
		for (int i = 0; i < 16; i++) begin
			v = (24'h000001 << i) ^ {24{i[0]}};
			wait_fall();
			take(5, fr(1'b0, 1'b0, 1'b0, v));
		end
		chk_val("drained", 32'h1, {31'h0, sample_ready});
		wait_fall();
		take(5, fr(1'b0, 1'b0, 1'b0, v));
	endtask
	// ----------------------------------------
	// Main sequence and verdict
	// ----------------------------------------
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		sample_valid = 1'b0;
		sample_data = '0;
		sample_osc = 1'b0;
		chan_sel = 1'b0;
		repeat (12) @(negedge clk);
		reset = 1'b0;
		t_start();
		t_overrange();
		t_switch();
		t_unread();
		t_fifo();
		chk_rng("cal cycles", 1, LIMIT, cal_seen);
		stop_test();
	end
endmodule
`default_nettype wire
